/* shared/dpm_pkg.sv */
// constants, offsets and types of the code point to priority map
package dpm_pkg;
   // widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int PRIO_W = 2;
   localparam int CODE_W = 6;
   localparam int CODE_COUNT = 64;
   localparam int MAP_W = CODE_COUNT * PRIO_W;
   localparam int FIELDS_PER_WORD = 8;
   localparam int MAP_WORDS = 5;
   // codes 0..23 live in the three lower map words outside this block
   localparam int LOWER_CODES = 24;
   localparam int LOWER_W = LOWER_CODES * PRIO_W;
   // code point position inside the tos / traffic class byte
   localparam int CODE_LSB = 2;
   localparam int CODE_MSB = 7;
   // register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_MAP_24_31 = 16'h0486;
   localparam logic [ADDR_W-1:0] IDX_MAP_32_39 = 16'h0488;
   localparam logic [ADDR_W-1:0] IDX_MAP_40_47 = 16'h048A;
   localparam logic [ADDR_W-1:0] IDX_MAP_48_55 = 16'h0490;
   localparam logic [ADDR_W-1:0] IDX_MAP_56_63 = 16'h0492;
   localparam logic [ADDR_W-1:0] IDX_LAST_CLASS = 16'h049C;
   // reset values
   localparam logic [REG_W-1:0] MAP_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;
   // last classification status layout
   localparam int LAST_CODE_LSB = 0;
   localparam int LAST_PRIO_LSB = 8;
   localparam int LAST_SEEN_BIT = 15;
   // apb response sequencing
   typedef enum logic [0:0] {
      DPM_IDLE,
      DPM_DONE
   } dpm_apb_state_type;
endpackage

/* shared/dpm_map_if.sv */
// carrier between the register bank and the priority lookup
`timescale 1ns/100ps
interface dpm_map_if;
   logic [dpm_pkg::MAP_W-1:0] map;
   logic [dpm_pkg::CODE_W-1:0] code;
   logic [dpm_pkg::PRIO_W-1:0] prio;
   modport bank (
      output map,
      output code,
      input prio
   );
   modport lookup (
      input map,
      input code,
      output prio
   );
endinterface

/* hw/dpm_lookup.sv */
// combinational code point to priority selection
`timescale 1ns/100ps
module dpm_lookup (
   // map and selected code in, priority out
   dpm_map_if.lookup lk
);
   logic [dpm_pkg::CODE_W:0] field_lsb;

   always_comb begin
      field_lsb = {lk.code, 1'b0};
      // one field per code point, no shared decode
      lk.prio = lk.map[field_lsb +: dpm_pkg::PRIO_W];
   end
endmodule

/* hw/dpm_map_upper.sv */
// upper code point priority map: apb register bank and ingress classifier
//
// Contract
// - priority comes from tos bits 7:2
// - word 0x486 maps tos 0x60..0x7C
// - word 0x488 maps tos 0x80..0x9C
// - word 0x48A maps tos 0xA0..0xBC
// - word 0x490 maps tos 0xC0..0xDC
// - word 0x492 maps tos 0xE0..0xFC
// - all fields reset zero, read back written
// - all 64 code points fully decoded
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
module dpm_map_upper (
   // clock and reset
   input wire logic CLOCK,
   input wire logic SRST,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [dpm_pkg::ADDR_W-1:0] PADDR,
   input wire logic [dpm_pkg::DATA_W-1:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [dpm_pkg::DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // lower map fields, codes 0..23, from the neighbouring bank
   input wire logic [dpm_pkg::LOWER_W-1:0] LOWER_MAP,
   // classification request
   input wire logic CLS_VALID,
   input wire logic [7:0] CLS_TOS,
   // classification result
   output logic PRIO_VALID,
   output logic [dpm_pkg::PRIO_W-1:0] PRIO,
   output logic [dpm_pkg::CODE_W-1:0] PRIO_CODE
);
   dpm_map_if map_bus ();

   // ---------------- apb address decode ----------------
   logic [dpm_pkg::ADDR_W-1:0] idx;
   logic addr_aligned;
   logic [dpm_pkg::MAP_WORDS-1:0] hit_map;
   logic hit_last;
   logic hit_any;
   logic access;

   always_comb begin
      idx = {2'b00, PADDR[dpm_pkg::ADDR_W-1:2]};
      addr_aligned = (PADDR[1:0] == 2'b00);
      hit_map[0] = addr_aligned && (idx == dpm_pkg::IDX_MAP_24_31);
      hit_map[1] = addr_aligned && (idx == dpm_pkg::IDX_MAP_32_39);
      hit_map[2] = addr_aligned && (idx == dpm_pkg::IDX_MAP_40_47);
      hit_map[3] = addr_aligned && (idx == dpm_pkg::IDX_MAP_48_55);
      hit_map[4] = addr_aligned && (idx == dpm_pkg::IDX_MAP_56_63);
      hit_last = addr_aligned && (idx == dpm_pkg::IDX_LAST_CLASS);
      hit_any = (|hit_map) || hit_last;
      access = PSEL && PENABLE;
   end

   // ---------------- apb response sequencing ----------------
   // one wait state: response registered, write lands on the ready edge
   dpm_pkg::dpm_apb_state_type state_r;
   dpm_pkg::dpm_apb_state_type state_nxt;
   logic [dpm_pkg::DATA_W-1:0] prdata_r;
   logic [dpm_pkg::DATA_W-1:0] prdata_nxt;
   logic pslverr_r;
   logic pslverr_nxt;
   logic [dpm_pkg::REG_W-1:0] map_r [dpm_pkg::MAP_WORDS];
   logic [dpm_pkg::REG_W-1:0] last_r;
   logic [dpm_pkg::REG_W-1:0] rd_word;
   logic wr_commit;

   always_comb begin
      rd_word = dpm_pkg::MAP_RESET;
      for (int w = 0; w < dpm_pkg::MAP_WORDS; w++) begin
         if (hit_map[w]) begin
            rd_word = map_r[w];
         end
      end
      if (hit_last) begin
         rd_word = last_r;
      end
   end

   always_comb begin
      state_nxt = state_r;
      prdata_nxt = prdata_r;
      pslverr_nxt = pslverr_r;
      wr_commit = 1'b0;
      case (state_r)
         dpm_pkg::DPM_IDLE: begin
            if (access) begin
               state_nxt = dpm_pkg::DPM_DONE;
               // status word is read only; writing it is refused
               pslverr_nxt = !hit_any || (PWRITE && hit_last);
               prdata_nxt = (!PWRITE && hit_any) ? {16'h0000, rd_word}
                                                 : dpm_pkg::RDATA_RESET;
            end
         end
         dpm_pkg::DPM_DONE: begin
            state_nxt = dpm_pkg::DPM_IDLE;
            wr_commit = access && PWRITE && !pslverr_r;
            pslverr_nxt = 1'b0;
         end
         default: begin
            state_nxt = dpm_pkg::DPM_IDLE;
            pslverr_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         state_r <= dpm_pkg::DPM_IDLE;
         prdata_r <= dpm_pkg::RDATA_RESET;
         pslverr_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         prdata_r <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   always_comb begin
      PREADY = (state_r == dpm_pkg::DPM_DONE);
      PRDATA = prdata_r;
      PSLVERR = pslverr_r && (state_r == dpm_pkg::DPM_DONE);
   end

   // ---------------- map words ----------------
   // only byte lanes 0 and 1 carry register bits; upper lanes are dropped
   logic [dpm_pkg::REG_W-1:0] map_nxt [dpm_pkg::MAP_WORDS];

   always_comb begin
      for (int w = 0; w < dpm_pkg::MAP_WORDS; w++) begin
         map_nxt[w] = map_r[w];
         if (wr_commit && hit_map[w]) begin
            if (PSTRB[0]) begin
               map_nxt[w][7:0] = PWDATA[7:0];
            end
            if (PSTRB[1]) begin
               map_nxt[w][15:8] = PWDATA[15:8];
            end
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      for (int w = 0; w < dpm_pkg::MAP_WORDS; w++) begin
         if (SRST) begin
            map_r[w] <= dpm_pkg::MAP_RESET;
         end else begin
            map_r[w] <= map_nxt[w];
         end
      end
   end

   // ---------------- lookup ----------------
   // word w field k serves code 24+8w+k, so the words simply stack
   logic [dpm_pkg::CODE_W-1:0] req_code;

   always_comb begin
      req_code = CLS_TOS[dpm_pkg::CODE_MSB:dpm_pkg::CODE_LSB];
      map_bus.code = req_code;
      map_bus.map = {map_r[4], map_r[3], map_r[2], map_r[1], map_r[0],
                     LOWER_MAP};
   end

   // live register contents feed the selector, so a completed write
   // applies from the very next request
   dpm_lookup u_lookup (
      .lk(map_bus.lookup)
   );

   // ---------------- classification result ----------------
   logic prio_valid_r;
   logic prio_valid_nxt;
   logic [dpm_pkg::PRIO_W-1:0] prio_r;
   logic [dpm_pkg::PRIO_W-1:0] prio_nxt;
   logic [dpm_pkg::CODE_W-1:0] code_r;
   logic [dpm_pkg::CODE_W-1:0] code_nxt;
   logic [dpm_pkg::REG_W-1:0] last_nxt;

   always_comb begin
      prio_valid_nxt = CLS_VALID;
      prio_nxt = prio_r;
      code_nxt = code_r;
      last_nxt = last_r;
      if (CLS_VALID) begin
         prio_nxt = map_bus.prio;
         code_nxt = req_code;
         last_nxt = dpm_pkg::MAP_RESET;
         last_nxt[dpm_pkg::LAST_CODE_LSB +: dpm_pkg::CODE_W] = req_code;
         last_nxt[dpm_pkg::LAST_PRIO_LSB +: dpm_pkg::PRIO_W] = map_bus.prio;
         last_nxt[dpm_pkg::LAST_SEEN_BIT] = 1'b1;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         prio_valid_r <= 1'b0;
         prio_r <= '0;
         code_r <= '0;
         last_r <= dpm_pkg::MAP_RESET;
      end else begin
         prio_valid_r <= prio_valid_nxt;
         prio_r <= prio_nxt;
         code_r <= code_nxt;
         last_r <= last_nxt;
      end
   end

   always_comb begin
      PRIO_VALID = prio_valid_r;
      PRIO = prio_r;
      PRIO_CODE = code_r;
   end
endmodule

/* tb/dpm_map_upper_asserts.sv */
// port assertions for the upper priority map
`timescale 1ns/100ps
module dpm_map_upper_asserts (
   // clock and reset
   input wire logic CLOCK,
   input wire logic SRST,
   // apb
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic [15:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // classifier
   input wire logic [47:0] LOWER_MAP,
   input wire logic CLS_VALID,
   input wire logic [7:0] CLS_TOS,
   input wire logic PRIO_VALID,
   input wire logic [1:0] PRIO,
   input wire logic [5:0] PRIO_CODE
);
   logic [1:0] low_sel;
   // only meaningful for codes below 24
   assign low_sel = LOWER_MAP[{CLS_TOS[7:2], 1'b0} +: 2];
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (SRST);
   valid_follow_a: assert property (CLS_VALID |=> PRIO_VALID)
      else $error("no result after request");
   no_spurious_a: assert property (!CLS_VALID |=> !PRIO_VALID)
      else $error("result without request");
   code_follow_a: assert property (CLS_VALID |=> {PRIO_CODE, 2'b00} == ($past(CLS_TOS) & 8'hFC))
      else $error("wrong code point");
   prio_hold_a: assert property (!CLS_VALID |=> $stable(PRIO) && $stable(PRIO_CODE))
      else $error("result moved without request");
   lower_pick_a: assert property (CLS_VALID && CLS_TOS < 8'h60 |=> PRIO == $past(low_sel))
      else $error("lower code priority wrong");
   ready_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("ready not after one wait");
   ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   err_align_a: assert property (PREADY && PADDR[1:0] != 2'h0 |-> PSLVERR)
      else $error("misaligned access accepted");
   map_ok_a: assert property (PREADY && PADDR inside {16'h1218, 16'h1220, 16'h1228, 16'h1240,
      16'h1248} |-> !PSLVERR)
      else $error("map word refused");
   rd_upper_a: assert property (PREADY |-> PRDATA[31:16] == 16'h0000)
      else $error("upper read bits set");
endmodule

bind dpm_map_upper dpm_map_upper_asserts i_chk (.*);

/* tb/dpm_map_upper_tb.sv */
// self-checking bench for the upper priority map
`timescale 1ns/100ps
module dpm_map_upper_tb;
   logic CLOCK = 0;
   logic SRST = 1;
   logic PSEL = 0, PENABLE = 0, PWRITE = 0, CLS_VALID = 0;
   logic PREADY, PSLVERR, PRIO_VALID, err;
   logic [15:0] PADDR = 16'h0000;
   logic [31:0] PWDATA = 32'h00000000, PRDATA, rd, v;
   logic [31:0] seed = 32'h7F8E;
   logic [47:0] LOWER_MAP = 48'h000000000000;
   logic [7:0] CLS_TOS = 8'h00;
   logic [1:0] PRIO;
   logic [5:0] PRIO_CODE;
   logic [15:0] mdl [5] = '{default: 16'h0000};
   localparam logic [15:0] ADR [5] = '{16'h1218, 16'h1220, 16'h1228, 16'h1240, 16'h1248};
   int n_errors = 0, cmp_count = 0, w;

   always #10 CLOCK = ~CLOCK;

   // byte strobes held full: the map honours PSTRB lanes 0 and 1, but partial writes are not exercised here
   dpm_map_upper i_dut (.*, .PSTRB(4'hF));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [1:0] exp_prio(input logic [5:0] c);
      logic [5:0] u;
      if (c < 24) return LOWER_MAP[2*c +: 2];
      u = c - 6'd24;
      return mdl[u[5:3]][2*u[2:0] +: 2];
   endfunction

   task automatic finish_test();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
      int n;
      @(posedge CLOCK);
      PSEL <= 1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1;
      n = 0;
      // look mid-cycle so the edge that launches ready is never raced
      do begin
         @(negedge CLOCK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      if (n == 20) begin
         n_errors++;
         finish_test();
      end
      rd = PRDATA;
      err = PSLVERR;
      @(posedge CLOCK);
      PSEL <= 0;
      PENABLE <= 0;
   endtask

   task automatic cls(input logic [7:0] t);
      @(posedge CLOCK);
      CLS_VALID <= 1;
      CLS_TOS <= t;
      @(posedge CLOCK);
      CLS_VALID <= 0;
      CLS_TOS <= ~t;
      // PRIO_VALID stands for one cycle only, PRIO and PRIO_CODE hold; sample inside that cycle
      @(negedge CLOCK);
      chk(PRIO_VALID, 1);
      chk(PRIO, exp_prio(t[7:2]));
      chk(PRIO_CODE, t[7:2]);
   endtask

   task automatic readall();
      for (int i = 0; i < 5; i++) begin
         apb(0, ADR[i], 0);
         chk(rd, {16'h0000, mdl[i]});
         chk(err, 0);
      end
   endtask

   initial begin
      repeat (2) @(posedge CLOCK);
      SRST <= 0;
      v = rnd();
      LOWER_MAP <= {v[15:0], rnd()};
      readall();
      repeat (3) begin
         for (int i = 0; i < 5; i++) begin
            v = rnd();
            mdl[i] = v[15:0];
            apb(1, ADR[i], v);
         end
         readall();
         for (int c = 0; c < 64; c++) begin
            v = rnd();
            cls({c[5:0], v[1:0]});
         end
      end
      apb(0, 16'h1230, 0);
      chk(err, 1);
      chk(rd, 0);
      apb(1, 16'h1219, 32'h0000FFFF);
      chk(err, 1);
      apb(1, 16'h1270, 32'h0000FFFF);
      chk(err, 1);
      readall();
      repeat (150) begin
         v = rnd();
         if (v[0]) begin
            w = v[3:1] % 5;
            mdl[w] = v[31:16];
            apb(1, ADR[w], {v[15:0], v[31:16]});
         end
         else cls(v[15:8]);
      end
      readall();
      cls(8'hFF);
      apb(0, 16'h1270, 0);
      chk(rd, {16'h0000, 1'b1, 5'h00, exp_prio(6'h3F), 2'b00, 6'h3F});
      chk(err, 0);
      @(posedge CLOCK);
      SRST <= 1;
      repeat (2) @(posedge CLOCK);
      SRST <= 0;
      mdl = '{default: 16'h0000};
      readall();
      finish_test();
   end
endmodule
